//--- design/mbd_defs.vh
// Constants for the MAC back-off and deferral controller
`ifndef MBD_DEFS_VH
`define MBD_DEFS_VH
`define MBD_DW 32
`define MBD_AW 4
`define MBD_A_CTRL 4'h0
`define MBD_A_STAT 4'h1
`define MBD_A_MASK 4'h2
`define MBD_A_STATE 4'h3
`define MBD_C_RECEIVE_ENABLE_BIT 2
`define MBD_C_TRANSMIT_ENABLE_BIT 3
`define MBD_C_DEFERRAL_CHECK_EN 5
`define MBD_C_BOL_LO 6
`define MBD_C_BOL_HI 7
`define MBD_CTRL_W 8
`define MBD_CTRL_RST 8'h00
`define MBD_CTRL_WMASK 8'hEC
`define MBD_S_RTY 0
`define MBD_S_DEF 1
`define MBD_S_DONE 2
`define MBD_S_COL 3
`define MBD_S_W 4
`define MBD_S_RST 4'h0
`define MBD_CLK_NS 50
`define MBD_BIT_NS_10 100
`define MBD_BIT_NS_100 10
`define MBD_SLOT_BITS 512
`define MBD_DEFER_BITS 24288
`define MBD_CNT_W 16
`define MBD_BO_W 10
`define MBD_ATT_W 5
`define MBD_MAX_ATT 5'h10
`define MBD_K_MAX 4'hA
`define MBD_K_W 4
`define MBD_BOL_10 2'h0
`define MBD_BOL_8 2'h1
`define MBD_BOL_4 2'h2
`define MBD_K_8 4'h8
`define MBD_K_4 4'h4
`define MBD_K_1 4'h1
`define MBD_LFSR_W 20
`define MBD_LFSR_SEED 20'h00001
`define MBD_LFSR_TAP 16
`define MBD_RX_DW 8
`define MBD_STW_HI 22
`define MBD_STW_PAD 4'h0
`endif

//--- design/mbd_lfsr.v
// Free-running 20-bit random source for back-off
`timescale 1ns/1ps
`include "mbd_defs.vh"
module mbd_lfsr (
  input wire mclk, // MAC clock
  input wire sys_rst, // Synchronous reset, active high
  input wire clk_en, // Clock enable
  output wire [`MBD_LFSR_W-1:0] lfsr_q // Current shift register state
);
  reg [`MBD_LFSR_W-1:0] lfsr_reg;
  wire fb;
  // Taps x^20 + x^17 + 1, maximal length; seed keeps it off all-zero
  assign fb = lfsr_reg[`MBD_LFSR_W-1] ^ lfsr_reg[`MBD_LFSR_TAP];
  always @(posedge mclk) begin
    if (sys_rst) begin
      lfsr_reg <= `MBD_LFSR_SEED;
    end else if (clk_en) begin
      lfsr_reg <= {lfsr_reg[`MBD_LFSR_W-2:0], fb};
    end
  end
  assign lfsr_q = lfsr_reg;
endmodule // mbd_lfsr

//--- design/mbd_ctrl.v
// MAC transmit back-off, deferral check and enable control
`timescale 1ns/1ps
`include "mbd_defs.vh"
// Function
// - Limit selector caps LFSR bits used: 00 ten, 01 eight, 10 four, 11 one.
// - A continuously running 20-bit LFSR supplies the random back-off value.
// - Random bit count K is min(retry number, 10); r lies in 0 to 2^K-1.
// - Selected low LFSR bits load a counter, decremented per slot, wait for zero.
// - With deferral checking on, abort attempt after deferring over 24,288 bit times.
// - Deferral timer counts while a frame is ready but carrier sense holds it.
// - Deferral timer clears to zero and restarts after each collision back-off.
// - With deferral checking off, never abort on deferral; wait indefinitely.
// - Transmit enable set lets frames go from the buffer onto the medium.
// - Transmit enable clear stops frames before they start; a frame already being sent is not cut off.
// - Receive enable set lets frames from the PHY be accepted.
// - Receive enable clear means no frame from the PHY is accepted.
// - Up to 16 attempts on repeated collisions, then a retry error.
module mbd_ctrl #(
  parameter DEFER_CYC_10 =
    (`MBD_DEFER_BITS * `MBD_BIT_NS_10) / `MBD_CLK_NS, // Deferral limit, 10 Mb/s
  parameter DEFER_CYC_100 =
    (`MBD_DEFER_BITS * `MBD_BIT_NS_100) / `MBD_CLK_NS // Deferral limit, 100 Mb/s
) (
  input wire mclk, // MAC clock, 20 MHz
  input wire sys_rst, // Synchronous reset, active high
  input wire clk_en, // Clock enable, freezes state when low
  input wire [`MBD_AW-1:0] reg_addr, // Register address
  input wire [`MBD_DW-1:0] reg_wdata, // Register write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [`MBD_DW-1:0] reg_rdata, // Read data, cycle after strobe
  input wire speed_100, // Link at 100 Mb/s when high
  input wire tx_frame_ready, // Buffer holds a frame to send
  input wire crs, // Carrier sense
  input wire tx_collision, // Collision during transmission
  input wire tx_done, // Frame finished on the medium
  output reg tx_start, // Pulse: begin sending frame
  output reg tx_active, // Transmission in progress
  output reg tx_abort, // Pulse: frame dropped, deferral or retries
  input wire rx_valid_in, // Receive beat from PHY
  input wire [`MBD_RX_DW-1:0] rx_data_in, // Receive data from PHY
  output reg rx_valid_out, // Accepted receive beat
  output reg [`MBD_RX_DW-1:0] rx_data_out, // Accepted receive data
  output reg irq // Level interrupt
);

  //////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 4'h1;
  localparam ST_DEFER = 4'h2;
  localparam ST_XMIT = 4'h4;
  localparam ST_BACK = 4'h8;
  // Slot is a least wait, so round up to whole cycles
  localparam SLOT_CYC_10 =
    (`MBD_SLOT_BITS * `MBD_BIT_NS_10 + `MBD_CLK_NS - 1) / `MBD_CLK_NS;
  localparam SLOT_CYC_100 =
    (`MBD_SLOT_BITS * `MBD_BIT_NS_100 + `MBD_CLK_NS - 1) / `MBD_CLK_NS;
  localparam integer SLOT_END_10 = SLOT_CYC_10 - 1;
  localparam integer SLOT_END_100 = SLOT_CYC_100 - 1;
  // Counters are 16 bits; every limit fits at either speed
  localparam [`MBD_CNT_W-1:0] SLOT_LAST_10 = SLOT_END_10[`MBD_CNT_W-1:0];
  localparam [`MBD_CNT_W-1:0] SLOT_LAST_100 = SLOT_END_100[`MBD_CNT_W-1:0];
  localparam [`MBD_CNT_W-1:0] DEF_LIM_10 = DEFER_CYC_10[`MBD_CNT_W-1:0];
  localparam [`MBD_CNT_W-1:0] DEF_LIM_100 = DEFER_CYC_100[`MBD_CNT_W-1:0];
  localparam [`MBD_CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam [`MBD_CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam [`MBD_CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam [`MBD_BO_W-1:0] BO_ONE = 10'h001;
  localparam [`MBD_BO_W-1:0] BO_ZERO = 10'h000;
  localparam [`MBD_ATT_W-1:0] ATT_ONE = 5'h01;
  localparam [`MBD_ATT_W-1:0] ATT_ZERO = 5'h00;

  //////////////////////////////////////////////////////////////////////
  // Back-off mask: K = min(n, 10), further capped by the limit code
  function [`MBD_BO_W-1:0] bo_mask;
    input [`MBD_ATT_W-1:0] n;
    input [1:0] sel;
    reg [`MBD_K_W-1:0] k;
    reg [`MBD_K_W-1:0] lim;
    integer i;
    begin
      k = (n > {1'b0, `MBD_K_MAX}) ? `MBD_K_MAX : n[`MBD_K_W-1:0];
      case (sel)
        `MBD_BOL_10: lim = `MBD_K_MAX;
        `MBD_BOL_8: lim = `MBD_K_8;
        `MBD_BOL_4: lim = `MBD_K_4;
        default: lim = `MBD_K_1;
      endcase
      if (lim < k) begin
        k = lim;
      end
      for (i = 0; i < `MBD_BO_W; i = i + 1) begin
        bo_mask[i] = (i < k);
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  reg [`MBD_CTRL_W-1:0] ctrl_reg;
  reg [`MBD_S_W-1:0] stat_reg;
  reg [`MBD_S_W-1:0] stat_next;
  reg [`MBD_S_W-1:0] mask_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [`MBD_CNT_W-1:0] defer_reg;
  reg [`MBD_CNT_W-1:0] defer_next;
  reg [`MBD_CNT_W-1:0] slot_reg;
  reg [`MBD_CNT_W-1:0] slot_next;
  reg [`MBD_BO_W-1:0] bo_reg;
  reg [`MBD_BO_W-1:0] bo_next;
  reg [`MBD_ATT_W-1:0] att_reg;
  reg [`MBD_ATT_W-1:0] att_next;
  reg start_next;
  reg abort_next;
  reg ev_rty;
  reg ev_def;
  reg ev_done;
  reg ev_col;
  reg [`MBD_DW-1:0] rd_next;
  wire [`MBD_LFSR_W-1:0] lfsr_q;
  wire tx_en_b;
  wire rx_en_b;
  wire deferral_check_en_b;
  wire [1:0] bol_sel;
  wire [`MBD_CNT_W-1:0] slot_last;
  wire [`MBD_CNT_W-1:0] def_lim;
  wire wr_ctrl;
  wire wr_stat;
  wire wr_mask;
  wire [`MBD_S_W-1:0] mask_eff;

  assign tx_en_b = ctrl_reg[`MBD_C_TRANSMIT_ENABLE_BIT];
  assign rx_en_b = ctrl_reg[`MBD_C_RECEIVE_ENABLE_BIT];
  assign deferral_check_en_b = ctrl_reg[`MBD_C_DEFERRAL_CHECK_EN];
  assign bol_sel = ctrl_reg[`MBD_C_BOL_HI:`MBD_C_BOL_LO];
  // Slot and deferral limit follow the current link speed
  assign slot_last = speed_100 ? SLOT_LAST_100 : SLOT_LAST_10;
  assign def_lim = speed_100 ? DEF_LIM_100 : DEF_LIM_10;
  assign wr_ctrl = reg_wr && (reg_addr == `MBD_A_CTRL);
  assign wr_stat = reg_wr && (reg_addr == `MBD_A_STAT);
  assign wr_mask = reg_wr && (reg_addr == `MBD_A_MASK);
  // A mask write counts in its own cycle, so irq never lags it
  assign mask_eff = wr_mask ? reg_wdata[`MBD_S_W-1:0] : mask_reg;

  // Runs even while idle, so each collision draws a fresh value
  mbd_lfsr u_lfsr (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .lfsr_q(lfsr_q)
  );

  //////////////////////////////////////////////////////////////////////
  // Transmit attempt sequencing
  always @* begin
    state_next = state_reg;
    defer_next = defer_reg;
    slot_next = slot_reg;
    bo_next = bo_reg;
    att_next = att_reg;
    start_next = 1'b0;
    abort_next = 1'b0;
    ev_rty = 1'b0;
    ev_def = 1'b0;
    ev_done = 1'b0;
    ev_col = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (tx_en_b && tx_frame_ready) begin
          state_next = ST_DEFER;
          defer_next = CNT_ZERO;
        end
      end
      ST_DEFER: begin
        if (!tx_en_b) begin
          // Disabled before the frame went out: nothing is sent
          state_next = ST_IDLE;
          att_next = ATT_ZERO;
        end else if (!crs) begin
          state_next = ST_XMIT;
          start_next = 1'b1;
        end else if (deferral_check_en_b && (defer_reg > def_lim)) begin
          state_next = ST_IDLE;
          abort_next = 1'b1;
          ev_def = 1'b1;
          att_next = ATT_ZERO;
        end else if (defer_reg != CNT_MAX) begin
          // Saturates; with checking off the wait has no limit
          defer_next = defer_reg + CNT_ONE;
        end
      end
      ST_XMIT: begin
        if (tx_collision) begin
          ev_col = 1'b1;
          if ((att_reg + ATT_ONE) >= `MBD_MAX_ATT) begin
            state_next = ST_IDLE;
            abort_next = 1'b1;
            ev_rty = 1'b1;
            att_next = ATT_ZERO;
          end else begin
            att_next = att_reg + ATT_ONE;
            bo_next = lfsr_q[`MBD_BO_W-1:0] &
              bo_mask(att_reg + ATT_ONE, bol_sel);
            slot_next = CNT_ZERO;
            state_next = ST_BACK;
          end
        end else if (tx_done) begin
          state_next = ST_IDLE;
          ev_done = 1'b1;
          att_next = ATT_ZERO;
        end
      end
      ST_BACK: begin
        if (bo_reg == BO_ZERO) begin
          // Fresh deferral window for the next attempt
          state_next = ST_DEFER;
          defer_next = CNT_ZERO;
        end else if (slot_reg >= slot_last) begin
          slot_next = CNT_ZERO;
          bo_next = bo_reg - BO_ONE;
        end else begin
          slot_next = slot_reg + CNT_ONE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Sticky status: a new event beats a same-cycle clear
  always @* begin
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = stat_reg & ~reg_wdata[`MBD_S_W-1:0];
    end
    if (ev_rty) begin
      stat_next[`MBD_S_RTY] = 1'b1;
    end
    if (ev_def) begin
      stat_next[`MBD_S_DEF] = 1'b1;
    end
    if (ev_done) begin
      stat_next[`MBD_S_DONE] = 1'b1;
    end
    if (ev_col) begin
      stat_next[`MBD_S_COL] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  always @* begin
    rd_next = {`MBD_DW{1'b0}};
    case (reg_addr)
      `MBD_A_CTRL: rd_next[`MBD_CTRL_W-1:0] = ctrl_reg;
      `MBD_A_STAT: rd_next[`MBD_S_W-1:0] = stat_reg;
      `MBD_A_MASK: rd_next[`MBD_S_W-1:0] = mask_reg;
      `MBD_A_STATE: rd_next[`MBD_STW_HI:0] = {att_reg, bo_reg, `MBD_STW_PAD, state_reg};
      default: rd_next = {`MBD_DW{1'b0}};
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Control, mask and sticky status registers
  always @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_reg <= `MBD_CTRL_RST;
      stat_reg <= `MBD_S_RST;
      mask_reg <= `MBD_S_RST;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        // Reserved control bits stay zero
        ctrl_reg <= reg_wdata[`MBD_CTRL_W-1:0] & `MBD_CTRL_WMASK;
      end
      if (wr_mask) begin
        mask_reg <= reg_wdata[`MBD_S_W-1:0];
      end
      stat_reg <= stat_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Attempt sequencer state and counters
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      defer_reg <= CNT_ZERO;
      slot_reg <= CNT_ZERO;
      bo_reg <= BO_ZERO;
      att_reg <= ATT_ZERO;
    end else if (clk_en) begin
      state_reg <= state_next;
      defer_reg <= defer_next;
      slot_reg <= slot_next;
      bo_reg <= bo_next;
      att_reg <= att_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Transmit handshake outputs
  always @(posedge mclk) begin
    if (sys_rst) begin
      tx_start <= 1'b0;
      tx_active <= 1'b0;
      tx_abort <= 1'b0;
    end else if (clk_en) begin
      tx_start <= start_next;
      tx_active <= (state_next == ST_XMIT);
      tx_abort <= abort_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Receive gate
  always @(posedge mclk) begin
    if (sys_rst) begin
      rx_valid_out <= 1'b0;
      rx_data_out <= {`MBD_RX_DW{1'b0}};
    end else if (clk_en) begin
      // Gating is per beat, so disabling mid-frame truncates it
      rx_valid_out <= rx_valid_in && rx_en_b;
      rx_data_out <= rx_en_b ? rx_data_in : {`MBD_RX_DW{1'b0}};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read data and interrupt
  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= {`MBD_DW{1'b0}};
      irq <= 1'b0;
    end else if (clk_en) begin
      if (reg_rd) begin
        reg_rdata <= rd_next;
      end else begin
        reg_rdata <= {`MBD_DW{1'b0}};
      end
      irq <= |(stat_next & mask_eff);
    end
  end

endmodule // mbd_ctrl

//--- testbench/mbd_ctrl_chk.sv
// Port-level assertions for the back-off and deferral controller
`timescale 1ns/1ps
`include "mbd_defs.vh"
module mbd_ctrl_chk (
  input logic mclk, // Clock
  input logic sys_rst, // Reset
  input logic clk_en, // Clock enable
  input logic reg_rd, // Read strobe
  input logic [`MBD_DW-1:0] reg_rdata, // Read data
  input logic crs, // Carrier sense
  input logic tx_collision, // Collision
  input logic tx_done, // Frame end
  input logic tx_start, // Start pulse
  input logic tx_active, // Sending
  input logic tx_abort, // Abort pulse
  input logic rx_valid_in, // Beat in
  input logic [`MBD_RX_DW-1:0] rx_data_in, // Data in
  input logic rx_valid_out, // Beat out
  input logic [`MBD_RX_DW-1:0] rx_data_out // Data out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  start_one_cycle_a: assert property (tx_start && clk_en |=> !tx_start)
    else $error("start pulse too long");
  start_sets_active_a: assert property (tx_start |-> tx_active)
    else $error("start without active");
  start_after_quiet_a: assert property ($rose(tx_start) |-> !$past(crs))
    else $error("start while carrier sensed");
  abort_one_cycle_a: assert property (tx_abort && clk_en |=> !tx_abort)
    else $error("abort pulse too long");
  abort_idle_a: assert property (tx_abort |-> !tx_active && !tx_start)
    else $error("abort while sending");
  done_ends_tx_a: assert property (tx_active && tx_done && clk_en |=> !tx_active)
    else $error("active after done");
  col_ends_tx_a: assert property (tx_active && tx_collision && clk_en |=> !tx_active)
    else $error("active after collision");
  rx_gate_a: assert property (rx_valid_out && $past(clk_en) |-> $past(rx_valid_in))
    else $error("beat out without beat in");
  rx_data_a: assert property (rx_valid_out && $past(clk_en) |->
    rx_data_out == $past(rx_data_in))
    else $error("receive data changed");
  rdata_quiet_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 0)
    else $error("read data outside read cycle");
endmodule // mbd_ctrl_chk
bind mbd_ctrl mbd_ctrl_chk chk_u (.mclk, .sys_rst, .clk_en, .reg_rd, .reg_rdata, .crs,
  .tx_collision, .tx_done, .tx_start, .tx_active, .tx_abort, .rx_valid_in, .rx_data_in,
  .rx_valid_out, .rx_data_out);

//--- testbench/mbd_phy_model.sv
// Medium model: ends each attempt with a collision or a frame end
`timescale 1ns/1ps
module mbd_phy_model (
  input logic mclk, // Clock
  input logic tx_start, // Start pulse
  input logic col_on, // Collide on every attempt
  input logic clr, // Clear statistics
  output logic tx_collision = 1'h0, // Collision pulse
  output logic tx_done = 1'h0, // Frame end pulse
  output int n_starts = 0, // Attempts seen
  output int max_gap = 0 // Longest start spacing
);
  int dly = 0;
  int gap = 0;
  always @(posedge mclk) begin
    tx_collision <= 1'h0;
    tx_done <= 1'h0;
    gap <= gap + 1;
    if (clr) begin
      n_starts <= 0;
      max_gap <= 0;
      gap <= 0;
    end else if (tx_start) begin
      n_starts <= n_starts + 1;
      if (gap > max_gap) max_gap <= gap;
      gap <= 0;
      dly <= 4;
    end else if (dly == 1) begin
      tx_collision <= col_on;
      tx_done <= !col_on;
      dly <= 0;
    end else if (dly > 1) dly <= dly - 1;
  end
endmodule // mbd_phy_model

//--- testbench/mbd_ctrl_tb.sv
// Testbench for the back-off and deferral controller
`timescale 1ns/1ps
`include "mbd_defs.vh"
module mbd_ctrl_tb;
  logic mclk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic speed_100 = 1'h0, tx_frame_ready = 1'h0, crs = 1'h0, rx_valid_in = 1'h0;
  logic col_on = 1'h0, clr = 1'h0;
  logic [`MBD_AW-1:0] reg_addr = 4'h0;
  logic [`MBD_DW-1:0] reg_wdata = 32'h0;
  logic [`MBD_RX_DW-1:0] rx_data_in = 8'h0;
  wire [`MBD_DW-1:0] reg_rdata;
  wire [`MBD_RX_DW-1:0] rx_data_out;
  wire tx_start, tx_active, tx_abort, tx_collision, tx_done, rx_valid_out, irq;
  int n_errors = 0, cmp_count = 0, n_starts, max_gap, n;
  always #25 mclk = ~mclk;
  mbd_ctrl #(.DEFER_CYC_10(20), .DEFER_CYC_100(10)) dut_u (.mclk, .sys_rst, .clk_en,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .speed_100, .tx_frame_ready, .crs,
    .tx_collision, .tx_done, .tx_start, .tx_active, .tx_abort, .rx_valid_in, .rx_data_in,
    .rx_valid_out, .rx_data_out, .irq);
  mbd_phy_model phy_u (.mclk, .tx_start, .col_on, .clr, .tx_collision, .tx_done, .n_starts,
    .max_gap);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  // Sampling at the edge sees the value of the cycle just ended
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(posedge mclk);
    chk(reg_rdata & m, exp);
  endtask
  task automatic wait_ev(input bit abrt, input int lim, input bit must);
    n = 0;
    while (n < lim && (abrt ? tx_abort : tx_start) !== 1'h1) begin
      @(posedge mclk);
      n++;
    end
    if (must && n == lim) begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
  endtask
  task automatic rx_beat(input logic [7:0] d, input logic v);
    rx_data_in <= d;
    rx_valid_in <= 1'h1;
    @(posedge mclk);
    rx_valid_in <= 1'h0;
    @(posedge mclk);
    chk(rx_valid_out, v);
    chk(rx_data_out, v ? d : 8'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    for (int a = 0; a < 3; a++) rd(a[3:0], 32'h0, 32'hFFFFFFFF);
    rd(4'h3, 32'h1, 32'hF);
    wr(4'h0, 32'hFFFFFFFF);
    rd(4'h0, 32'hEC, 32'hFFFFFFFF);
    rd(4'h9, 32'h0, 32'hFFFFFFFF);
    rx_beat(8'hA5, 1'h1);
    wr(4'h0, 32'h28);
    rx_beat(8'h3C, 1'h0);
    $display("Test registers and receive gate done");
    wr(4'h2, 32'hF);
    for (int s = 0; s < 2; s++) begin
      speed_100 <= s[0];
      crs <= 1'h1;
      tx_frame_ready <= 1'h1;
      wait_ev(1, 80, 1);
      tx_frame_ready <= 1'h0;
      chk(n >= (s ? 10 : 20) && n <= (s ? 20 : 30), 1'h1);
      // Frame is re-armed at the abort edge; tx enable off retires it
      wr(4'h0, 32'h20);
      rd(4'h1, 32'h2, 32'h2);
      rd(4'h3, 32'h1, 32'hF);
      chk(irq, 1'h1);
      wr(4'h1, 32'hF);
      @(posedge mclk);
      chk(irq, 1'h0);
      wr(4'h0, s ? 32'h08 : 32'h28);
    end
    $display("Test deferral abort done");
    tx_frame_ready <= 1'h1;
    wait_ev(1, 100, 0);
    chk(n, 100);
    crs <= 1'h0;
    wait_ev(0, 10, 1);
    tx_frame_ready <= 1'h0;
    repeat (10) @(posedge mclk);
    rd(4'h1, 32'h4, 32'h4);
    wr(4'h2, 32'h0);
    @(posedge mclk);
    chk(irq, 1'h0);
    wr(4'h2, 32'h4);
    @(posedge mclk);
    chk(irq, 1'h1);
    wr(4'h1, 32'hF);
    @(posedge mclk);
    chk(irq, 1'h0);
    $display("Test unlimited deferral and send done");
    wr(4'h0, 32'h00);
    tx_frame_ready <= 1'h1;
    wait_ev(0, 40, 0);
    chk(n, 40);
    tx_frame_ready <= 1'h0;
    $display("Test transmit disabled done");
    // One-bit limit keeps each back-off within a single slot
    wr(4'h0, 32'hC8);
    speed_100 <= 1'h1;
    col_on <= 1'h1;
    clr <= 1'h1;
    @(posedge mclk);
    clr <= 1'h0;
    tx_frame_ready <= 1'h1;
    wait_ev(1, 4000, 1);
    tx_frame_ready <= 1'h0;
    chk(n_starts, 16);
    chk(max_gap >= 103 && max_gap <= 125, 1'h1);
    rd(4'h1, 32'h1, 32'h1);
    $display("Test collision retries done");
    report_and_stop();
  end
endmodule // mbd_ctrl_tb
